// >>> verilog/mscp_regs.vh
// Purpose: constants of the modem serial control port
// Assumes: 200 MHz system clock, 1200 bit/s modem rate
// Notes: register offsets are byte addresses on the AXI4-Lite bus
`ifndef MSCP_REGS_VH
`define MSCP_REGS_VH

// register offsets
`define MSCP_OFF_CTRL 8'h00
`define MSCP_OFF_STATUS 8'h04
`define MSCP_OFF_SHIFT 8'h08
`define MSCP_OFF_MODE_PAT 8'h0c
`define MSCP_OFF_FRAME_PAT 8'h10
`define MSCP_OFF_INT_STAT 8'h14
`define MSCP_OFF_INT_MASK 8'h18

// control fields
`define MSCP_CTRL_TX_EN 0
`define MSCP_CTRL_RST_VAL 32'h0000_0001
`define MSCP_CTRL_TX_EN_RST 1'b1

// status fields
`define MSCP_ST_FRAME 0
`define MSCP_ST_MODE_MATCH 1
`define MSCP_ST_TEST 2
`define MSCP_ST_SEL 3
`define MSCP_ST_TX_EN 4

// interrupt events
`define MSCP_EV_COMMIT 0
`define MSCP_EV_FRAME 1
`define MSCP_EV_TX_BIT 2
`define MSCP_EV_RX_BIT 3
`define MSCP_EV_W 4

// bus answers
`define MSCP_RESP_OKAY 2'b00
`define MSCP_RESP_SLVERR 2'b10

// timing
`define MSCP_CLK_HZ 200000000
`define MSCP_BAUD 1200
`define MSCP_HALF_BIT (`MSCP_CLK_HZ / (`MSCP_BAUD * 2))

`endif

// >>> verilog/mscp_sync.v
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clk_i
// Notes: per-bit reset value lets pulled-up pins read high after reset
`timescale 1ns/1ps
module mscp_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // data
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // mscp_sync

// >>> verilog/mscp_pat_match.v
// Purpose: compares the received bit stream with a programmed pattern
// Assumes: bit_en_i is a one-cycle pulse per received bit
// Notes: no match is reported until a full pattern of bits has arrived
`timescale 1ns/1ps
module mscp_pat_match #(
  parameter PAT_W = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // stream
  input wire bit_en_i,
  input wire bit_i,
  input wire [PAT_W-1:0] pattern_i,
  // result
  output wire match_o
);
  reg [PAT_W-1:0] hist_q;
  reg [PAT_W:0] fill_q;

  // fill_q is a one-hot run that marks how many bits were seen
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist_q <= {PAT_W{1'b0}};
      fill_q <= {{PAT_W{1'b0}}, 1'b1};
    end else if (bit_en_i) begin
      hist_q <= {hist_q[PAT_W-2:0], bit_i};
      if (!fill_q[PAT_W]) begin
        fill_q <= {fill_q[PAT_W-1:0], 1'b0};
      end
    end
  end

  assign match_o = fill_q[PAT_W] && (hist_q == pattern_i);
endmodule // mscp_pat_match

// >>> verilog/mscp_top.v
// Purpose: serial control port and bit timing of an MSK modem
// Assumes: pins asynchronous to clk_i; rx_demod_bit_i comes from clk_i logic
// Notes: registers on AXI4-Lite; pull-ups are pad cells, modelled as
//   reset values of the pin synchronisers
`timescale 1ns/1ps
`include "mscp_regs.vh"
module mscp_top #(
  parameter PAT_W = 16,
  parameter [PAT_W-1:0] INIT_MODE_PAT = {PAT_W{1'b0}},
  parameter [PAT_W-1:0] INIT_FRAME_PAT = {PAT_W{1'b0}},
  parameter HALF_BIT = `MSCP_HALF_BIT
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // serial control pins
  input wire ctrl_shift_clock_i,
  input wire ctrl_serial_data_i,
  input wire serial_word_strobe_i,
  input wire pattern_test_mode_i,
  input wire pattern_select_i,
  output wire pattern_check_o,
  // frame detection
  input wire frame_flag_clear_n_i,
  output wire frame_detect_flag_o,
  // modem data
  input wire tx_bit_input_i,
  input wire tx_enable_i,
  output wire tx_bit_clock_o,
  output wire tx_mod_data_o,
  input wire rx_demod_bit_i,
  output wire rx_bit_clock_o,
  output wire rx_data_o,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // interrupt
  output wire irq_o
);
  localparam CNT_W = 18;
  // counter width limits HALF_BIT to 2**18 cycles
  localparam integer HALF_LAST_I = HALF_BIT - 1;
  localparam [CNT_W-1:0] HALF_LAST = HALF_LAST_I[CNT_W-1:0];

  // decode a byte address to a register index, 7 means unmapped
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      if (addr == `MSCP_OFF_CTRL) begin
        reg_index = 3'd0;
      end else if (addr == `MSCP_OFF_STATUS) begin
        reg_index = 3'd1;
      end else if (addr == `MSCP_OFF_SHIFT) begin
        reg_index = 3'd2;
      end else if (addr == `MSCP_OFF_MODE_PAT) begin
        reg_index = 3'd3;
      end else if (addr == `MSCP_OFF_FRAME_PAT) begin
        reg_index = 3'd4;
      end else if (addr == `MSCP_OFF_INT_STAT) begin
        reg_index = 3'd5;
      end else if (addr == `MSCP_OFF_INT_MASK) begin
        reg_index = 3'd6;
      end else begin
        reg_index = 3'd7;
      end
    end
  endfunction

  // reset release through two flops
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // pin synchronisers; test and clear pins idle high like their pull-ups
  wire [6:0] pins_s;

  mscp_sync #(
    .W(7),
    .RST_VAL(7'h18)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i({tx_bit_input_i, pattern_select_i, frame_flag_clear_n_i, pattern_test_mode_i,
      serial_word_strobe_i, ctrl_serial_data_i, ctrl_shift_clock_i}),
    .q_o(pins_s)
  );
  wire sck_s = pins_s[0];
  wire sdi_s = pins_s[1];
  wire stb_s = pins_s[2];
  wire test_s = pins_s[3];
  wire fclr_n_s = pins_s[4];
  wire sel_s = pins_s[5];
  wire txd_s = pins_s[6];

  // edge finders on synchronised shift clock and strobe
  reg sck_prev_q;
  reg stb_prev_q;
  wire sck_rise = sck_s && !sck_prev_q;
  wire stb_rise = stb_s && !stb_prev_q;

  // control shift register and committed patterns
  reg [PAT_W-1:0] shift_q;
  reg [PAT_W-1:0] mode_pat_q;
  reg [PAT_W-1:0] frame_pat_q;
  reg check_q;

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
      stb_prev_q <= 1'b0;
      shift_q <= {PAT_W{1'b0}};
      mode_pat_q <= INIT_MODE_PAT;
      frame_pat_q <= INIT_FRAME_PAT;
      check_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      stb_prev_q <= stb_s;
      if (sck_rise) begin
        if (test_s) begin
          shift_q <= {shift_q[PAT_W-2:0], sdi_s};
          check_q <= shift_q[PAT_W-1];
        end else begin
          shift_q <= sel_s ? frame_pat_q : mode_pat_q;
        end
      end
      // strobe is meant to come with the shift clock idle
      if (stb_rise) begin
        if (sel_s) begin
          frame_pat_q <= shift_q;
        end else begin
          mode_pat_q <= shift_q;
        end
      end
    end
  end

  // bit-rate dividers: one tick per half bit and one bit enable per full bit for each direction
  reg [CNT_W-1:0] tx_cnt_q;
  reg [CNT_W-1:0] rx_cnt_q;
  reg tx_clk_q;
  reg rx_clk_q;
  wire tx_half = (tx_cnt_q == HALF_LAST);
  wire rx_half = (rx_cnt_q == HALF_LAST);
  wire tx_bit_en = tx_half && !tx_clk_q;
  wire rx_bit_en = rx_half && !rx_clk_q;

  // transmit and receive data
  reg tx_bit_q;
  reg tx_mod_q;
  reg rx_data_q;
  reg ctrl_tx_en_q;

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_q <= {CNT_W{1'b0}};
      rx_cnt_q <= {CNT_W{1'b0}};
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
      tx_bit_q <= 1'b0;
      tx_mod_q <= 1'b0;
      rx_data_q <= 1'b0;
    end else begin
      tx_cnt_q <= tx_half ? {CNT_W{1'b0}} : tx_cnt_q + 1'b1;
      rx_cnt_q <= rx_half ? {CNT_W{1'b0}} : rx_cnt_q + 1'b1;
      if (tx_half) begin
        tx_clk_q <= !tx_clk_q;
      end
      if (rx_half) begin
        rx_clk_q <= !rx_clk_q;
      end
      if (tx_bit_en) begin
        tx_bit_q <= txd_s;
      end
      if (rx_bit_en) begin
        rx_data_q <= rx_demod_bit_i;
      end
      // muting is immediate, not waiting for a bit boundary
      tx_mod_q <= tx_enable_i && ctrl_tx_en_q && tx_bit_q;
    end
  end

  // pattern comparison on the received stream
  wire pat_match;
  reg match_prev_q;
  reg frame_q;
  wire frame_hit = pat_match && sel_s && !match_prev_q;

  mscp_pat_match #(
    .PAT_W(PAT_W)
  ) u_match (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .bit_en_i(rx_bit_en),
    .bit_i(rx_demod_bit_i),
    .pattern_i(sel_s ? frame_pat_q : mode_pat_q),
    .match_o(pat_match)
  );

  // clear wins over a match in the same cycle, as the pin forces low
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= 1'b0;
      match_prev_q <= 1'b0;
    end else begin
      match_prev_q <= pat_match && sel_s;
      if (!fclr_n_s) begin
        frame_q <= 1'b0;
      end else if (pat_match && sel_s) begin
        frame_q <= 1'b1;
      end
    end
  end

  // register file state
  reg [`MSCP_EV_W-1:0] int_stat_q;
  reg [`MSCP_EV_W-1:0] int_mask_q;
  reg irq_q;
  wire [`MSCP_EV_W-1:0] events;
  assign events = {rx_bit_en, tx_bit_en, frame_hit && fclr_n_s, stb_rise};

  // axi write path
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire [2:0] widx = reg_index(awaddr_q);
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wbits = wdata_q & wmask;
  reg [`MSCP_EV_W-1:0] int_clr;

  always @* begin
    int_clr = {`MSCP_EV_W{1'b0}};
    if (do_write && widx == 3'd5) begin
      int_clr = wbits[`MSCP_EV_W-1:0];
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `MSCP_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_tx_en_q <= `MSCP_CTRL_TX_EN_RST;
      int_mask_q <= {`MSCP_EV_W{1'b0}};
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (widx == 3'd7) ? `MSCP_RESP_SLVERR : `MSCP_RESP_OKAY;
        if (widx == 3'd0 && wstrb_q[0]) begin
          ctrl_tx_en_q <= wdata_q[`MSCP_CTRL_TX_EN];
        end else if (widx == 3'd6 && wstrb_q[0]) begin
          int_mask_q <= wdata_q[`MSCP_EV_W-1:0];
        end
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // sticky events: a new event beats a write-one-to-clear
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_q <= {`MSCP_EV_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~int_clr) | events;
      irq_q <= |(((int_stat_q & ~int_clr) | events) & int_mask_q);
    end
  end

  // axi read path
  reg arready_q;
  reg rvalid_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_q;
  reg [31:0] rd_val;
  wire [2:0] ridx = reg_index(s_axi_araddr);

  always @* begin
    rd_val = 32'h0000_0000;
    case (ridx)
      3'd0: rd_val[`MSCP_CTRL_TX_EN] = ctrl_tx_en_q;
      3'd1: begin
        rd_val[`MSCP_ST_FRAME] = frame_q;
        rd_val[`MSCP_ST_MODE_MATCH] = pat_match && !sel_s;
        rd_val[`MSCP_ST_TEST] = test_s;
        rd_val[`MSCP_ST_SEL] = sel_s;
        rd_val[`MSCP_ST_TX_EN] = tx_enable_i;
      end
      3'd2: rd_val[PAT_W-1:0] = shift_q;
      3'd3: rd_val[PAT_W-1:0] = mode_pat_q;
      3'd4: rd_val[PAT_W-1:0] = frame_pat_q;
      3'd5: rd_val[`MSCP_EV_W-1:0] = int_stat_q;
      3'd6: rd_val[`MSCP_EV_W-1:0] = int_mask_q;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `MSCP_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_q <= (ridx == 3'd7) ? `MSCP_RESP_SLVERR : `MSCP_RESP_OKAY;
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // outputs
  assign pattern_check_o = check_q;
  assign frame_detect_flag_o = frame_q;
  assign tx_bit_clock_o = tx_clk_q;
  assign tx_mod_data_o = tx_mod_q;
  assign rx_bit_clock_o = rx_clk_q;
  assign rx_data_o = rx_data_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign irq_o = irq_q;
endmodule // mscp_top

// >>> verif/mscp_monitor.sv
// Purpose: port checker of mscp_top
// Assumes: pins change far apart compared with the sync delay
// Notes: pin windows allow for the two-flop synchronisers
`timescale 1ns/1ps
module mscp_monitor #(
  parameter HALF_BIT = 8
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // pins
  input wire ctrl_shift_clock_i,
  input wire pattern_select_i,
  input wire pattern_check_o,
  input wire frame_flag_clear_n_i,
  input wire frame_detect_flag_o,
  input wire tx_enable_i,
  input wire tx_bit_clock_o,
  input wire tx_mod_data_o,
  input wire rx_bit_clock_o,
  input wire rx_data_o,
  // bus
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready
);
  reg [31:0] cnt_q;
  reg prev_q;
  reg seen_q;
  wire tog = tx_bit_clock_o != prev_q;
  // first toggle after reset ends a partial phase, so it is not judged
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 32'h0;
      prev_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      cnt_q <= tog ? 32'h0 : cnt_q + 32'h1;
      prev_q <= tx_bit_clock_o;
      seen_q <= seen_q | tog;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_clr_low; !frame_flag_clear_n_i [*4]; endsequence
  sequence s_kept; (frame_detect_flag_o && frame_flag_clear_n_i) [*4]; endsequence
  property p_clear; s_clr_low |=> !frame_detect_flag_o; endproperty
  property p_hold; s_kept |=> frame_detect_flag_o; endproperty
  property p_set;
    $rose(frame_detect_flag_o) |-> $past(frame_flag_clear_n_i, 3) && $past(pattern_select_i, 3);
  endproperty
  property p_mute; !tx_enable_i [*2] |=> !tx_mod_data_o; endproperty
  property p_rx; $changed(rx_data_o) |-> rx_bit_clock_o; endproperty
  property p_check; $changed(pattern_check_o) |-> $past(ctrl_shift_clock_i, 3); endproperty
  property p_half; tog && seen_q |-> cnt_q == HALF_BIT - 1; endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_clear: assert property (p_clear) else $error("flag high under clear");
  a_hold: assert property (p_hold) else $error("flag dropped");
  a_set: assert property (p_set) else $error("flag set unexpectedly");
  a_mute: assert property (p_mute) else $error("tx not muted");
  a_rx: assert property (p_rx) else $error("rx data off clock rise");
  a_check: assert property (p_check) else $error("check out off shift clock");
  a_half: assert property (p_half) else $error("tx bit clock phase length");
  a_bhold: assert property (p_bhold) else $error("write response not held");
endmodule // mscp_monitor
bind mscp_top mscp_monitor #(.HALF_BIT(HALF_BIT)) u_mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ctrl_shift_clock_i(ctrl_shift_clock_i),
  .pattern_select_i(pattern_select_i), .pattern_check_o(pattern_check_o),
  .frame_flag_clear_n_i(frame_flag_clear_n_i), .frame_detect_flag_o(frame_detect_flag_o),
  .tx_enable_i(tx_enable_i), .tx_bit_clock_o(tx_bit_clock_o), .tx_mod_data_o(tx_mod_data_o),
  .rx_bit_clock_o(rx_bit_clock_o), .rx_data_o(rx_data_o), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// >>> verif/mscp_host.sv
// Purpose: host processor model on the serial control pins
// Assumes: 80 ns shift clock, 5 ns system clock
// Notes: shift clock and strobe rest low outside a word
`timescale 1ns/1ps
module mscp_host (
  // clock
  input wire clk_i,
  // pins
  output reg sck_o,
  output reg sdata_o,
  output reg strobe_o,
  output reg clr_n_o
);
  initial begin
    sck_o = 1'b0;
    sdata_o = 1'b0;
    strobe_o = 1'b0;
    clr_n_o = 1'b1;
  end
  // n bits msb first; data moves only while the clock is low
  task shift(input [15:0] w, input integer n, input commit);
    integer i;
    begin
      for (i = n - 1; i >= 0; i = i - 1) begin
        repeat (4) @(posedge clk_i);
        sdata_o <= w[i];
        repeat (4) @(posedge clk_i);
        sck_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        sck_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      sdata_o <= ~sdata_o;
      if (commit) begin
        repeat (4) @(posedge clk_i);
        strobe_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        strobe_o <= 1'b0;
        repeat (8) @(posedge clk_i);
      end
    end
  endtask
  task clear;
    begin
      @(posedge clk_i);
      clr_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      clr_n_o <= 1'b1;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule // mscp_host

// >>> verif/testbench.sv
// Purpose: self-checking bench of mscp_top
// Assumes: bit clock half period cut to 8 cycles
// Notes: host model drives the serial control pins
`timescale 1ns/1ps
`include "mscp_regs.vh"
module testbench;
  localparam [15:0] MPAT = 16'ha5c6;
  localparam [15:0] FPAT = 16'hb38d;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg test = 1'b1, sel = 1'b0, txb = 1'b0, txen = 1'b0, rxb = 1'b0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  wire sck, sdat, stb, clr_n, check, flag, txclk, txmod, rxclk, rxd;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer error_cnt = 0, n_tests = 0, cyc = 0;
  mscp_host host (.clk_i(clk_i), .sck_o(sck), .sdata_o(sdat), .strobe_o(stb), .clr_n_o(clr_n));
  mscp_top #(.HALF_BIT(8)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ctrl_shift_clock_i(sck), .ctrl_serial_data_i(sdat),
    .serial_word_strobe_i(stb), .pattern_test_mode_i(test), .pattern_select_i(sel),
    .pattern_check_o(check), .frame_flag_clear_n_i(clr_n), .frame_detect_flag_o(flag),
    .tx_bit_input_i(txb), .tx_enable_i(txen), .tx_bit_clock_o(txclk), .tx_mod_data_o(txmod),
    .rx_demod_bit_i(rxb), .rx_bit_clock_o(rxclk), .rx_data_o(rxd),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_o(irq));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (exp !== got) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // bready is raised late on purpose, so the response must stand meanwhile
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg aw_done, w_done;
    begin
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      // each channel drops valid only after the edge that took it
      while (!(aw_done && w_done)) begin
        @(posedge clk_i);
        if (!aw_done && awready) begin
          aw_done = 1'b1;
          awvalid <= 1'b0;
        end
        if (!w_done && wready) begin
          w_done = 1'b1;
          wvalid <= 1'b0;
        end
      end
      while (!bvalid) @(posedge clk_i);
      bready <= 1'b1;
      @(posedge clk_i);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
    begin
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge clk_i);
      while (!arready) @(posedge clk_i);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge clk_i);
      rready <= 1'b1;
      @(posedge clk_i);
      rready <= 1'b0;
      chk("rdata", exp, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
    end
  endtask
  task bit_rise(input rx);
    begin
      while (rx ? rxclk : txclk) @(posedge clk_i);
      while (!(rx ? rxclk : txclk)) @(posedge clk_i);
    end
  endtask
  task t_regs;
    begin
      rd(`MSCP_OFF_CTRL, `MSCP_CTRL_RST_VAL, `MSCP_RESP_OKAY);
      rd(8'h1c, 32'h0, `MSCP_RESP_SLVERR);
      wr(8'h40, 32'h1, `MSCP_RESP_SLVERR);
      wr(`MSCP_OFF_FRAME_PAT, 32'h1234, `MSCP_RESP_OKAY);
      rd(`MSCP_OFF_FRAME_PAT, 32'h0, `MSCP_RESP_OKAY);
    end
  endtask
  task t_serial;
    begin
      wr(`MSCP_OFF_INT_MASK, 32'h1, `MSCP_RESP_OKAY);
      host.shift(MPAT, 16, 1'b1);
      rd(`MSCP_OFF_SHIFT, {16'h0, MPAT}, `MSCP_RESP_OKAY);
      rd(`MSCP_OFF_MODE_PAT, {16'h0, MPAT}, `MSCP_RESP_OKAY);
      chk("irq", 32'h1, {31'h0, irq});
      wr(`MSCP_OFF_INT_STAT, 32'h1, `MSCP_RESP_OKAY);
      repeat (3) @(posedge clk_i);
      chk("irq_clr", 32'h0, {31'h0, irq});
      host.shift(16'h0, 1, 1'b0);
      chk("check_out", {31'h0, MPAT[15]}, {31'h0, check});
      sel <= 1'b1;
      host.shift(FPAT, 16, 1'b1);
      rd(`MSCP_OFF_FRAME_PAT, {16'h0, FPAT}, `MSCP_RESP_OKAY);
      rd(`MSCP_OFF_MODE_PAT, {16'h0, MPAT}, `MSCP_RESP_OKAY);
      chk("irq_set", 32'h1, {31'h0, irq});
      wr(`MSCP_OFF_INT_MASK, 32'h0, `MSCP_RESP_OKAY);
      repeat (3) @(posedge clk_i);
      chk("irq_mask", 32'h0, {31'h0, irq});
    end
  endtask
  task t_load;
    begin
      test <= 1'b0;
      host.shift(16'h0, 1, 1'b0);
      rd(`MSCP_OFF_SHIFT, {16'h0, FPAT}, `MSCP_RESP_OKAY);
      sel <= 1'b0;
      host.shift(16'hffff, 1, 1'b0);
      rd(`MSCP_OFF_SHIFT, {16'h0, MPAT}, `MSCP_RESP_OKAY);
      test <= 1'b1;
    end
  endtask
  task t_frame;
    integer k;
    begin
      sel <= 1'b1;
      host.clear();
      chk("flag_clr", 32'h0, {31'h0, flag});
      for (k = 15; k >= 0; k = k - 1) begin
        bit_rise(1'b1);
        rxb <= FPAT[k];
      end
      bit_rise(1'b1);
      rxb <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("rx_data", {31'h0, FPAT[0]}, {31'h0, rxd});
      chk("flag_set", 32'h1, {31'h0, flag});
      repeat (40) @(posedge clk_i);
      chk("flag_hold", 32'h1, {31'h0, flag});
      host.clear();
      chk("flag_clr2", 32'h0, {31'h0, flag});
    end
  endtask
  task t_tx;
    begin
      bit_rise(1'b0);
      txb <= 1'b1;
      txen <= 1'b1;
      bit_rise(1'b0);
      bit_rise(1'b0);
      repeat (3) @(posedge clk_i);
      chk("tx_on", 32'h1, {31'h0, txmod});
      txen <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("tx_mute", 32'h0, {31'h0, txmod});
      txen <= 1'b1;
      wr(`MSCP_OFF_CTRL, 32'h0, `MSCP_RESP_OKAY);
      repeat (20) @(posedge clk_i);
      chk("tx_ctrl", 32'h0, {31'h0, txmod});
    end
  endtask
  task t_reset;
    begin
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rd(`MSCP_OFF_MODE_PAT, 32'h0, `MSCP_RESP_OKAY);
      rd(`MSCP_OFF_SHIFT, 32'h0, `MSCP_RESP_OKAY);
      rd(`MSCP_OFF_CTRL, `MSCP_CTRL_RST_VAL, `MSCP_RESP_OKAY);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    t_regs;
    t_serial;
    t_load;
    t_frame;
    t_tx;
    t_reset;
    give_verdict;
  end
endmodule // testbench
